// ### pss_pkg.sv
// Constants, register map and state encoding for the start-up sequencer
package pss_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 32'h017D_7840;
  localparam int MS_PER_S = 32'h0000_03E8;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam logic [7:0] MEM_CHECK_MS = 8'h0F;
  localparam logic [7:0] PRE_RAMP_MS = 8'h07;

  // ----------------------------------------------------------------
  // Register map (word index on the plain port)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_SETPOINT = 4'h1;
  localparam logic [3:0] REG_DELAY = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_CEILING = 4'h4;
  localparam logic [3:0] REG_RAMP = 4'h5;
  localparam int CTRL_RESTORE_BIT = 0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_READY_BIT = 3;
  localparam int STAT_ON_BIT = 4;
  localparam int STAT_NVM_BIT = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [12:0] SETPOINT_RST = 13'h0000;
  localparam logic [7:0] DELAY_RST = 8'h00;
  localparam logic [7:0] RAMP_RST = 8'h00;

  // ----------------------------------------------------------------
  // Strap encodings and values
  // ----------------------------------------------------------------
  localparam logic [1:0] TRI_LOW = 2'b00;
  localparam logic [1:0] TRI_OPEN = 2'b01;
  localparam logic [1:0] TRI_HIGH = 2'b10;
  localparam logic [7:0] STRAP_MS_LOW = 8'h0A;
  localparam logic [7:0] STRAP_MS_OPEN = 8'h32;
  localparam logic [7:0] STRAP_MS_HIGH = 8'h64;
  localparam logic [12:0] SP_0V6_MV = 13'h0258;
  localparam logic [12:0] SP_0V8_MV = 13'h0320;
  localparam logic [12:0] SP_1V0_MV = 13'h03E8;
  localparam logic [12:0] SP_1V2_MV = 13'h04B0;
  localparam logic [12:0] SP_1V5_MV = 13'h05DC;
  localparam logic [12:0] SP_1V8_MV = 13'h0708;
  localparam logic [12:0] SP_2V5_MV = 13'h09C4;
  localparam logic [12:0] SP_3V3_MV = 13'h0CE4;
  localparam logic [12:0] SP_5V0_MV = 13'h1388;
  localparam logic [12:0] SP_BUS_MAX_MV = 13'h157C;
  localparam logic [12:0] COARSE_STEP_MV = 13'h00FA;
  localparam logic [12:0] FINE_STEP_MV = 13'h000A;
  localparam logic [4:0] IDX_MAX = 5'h18;
  localparam int CEIL_NUM = 32'h0000_000B;
  localparam int CEIL_DEN = 32'h0000_000A;

  typedef enum logic [2:0] {
    ST_PWR_WAIT = 3'b000,
    ST_MEM_CHECK = 3'b001,
    ST_STRAP = 3'b010,
    ST_READY = 3'b011,
    ST_PRE_RAMP = 3'b100,
    ST_RAMP = 3'b101,
    ST_ON = 3'b110
  } pss_state_t;

endpackage

// ### pss_seq.sv
// Power-up sequencer, strap sampler and setpoint decoder
//
// Overview of operation
// - Sequence starts only when all three supply inputs are present; fixed step order.
// - First step checks non-volatile memory for about ten to twenty milliseconds.
// - Values found stored in memory are loaded into the working configuration.
// - After memory, every strap pin is read; setpoint and delay straps load only when memory held no values.
// - Bus commands and enable are accepted only after memory and strap steps.
// - After enable, output stays off roughly seven milliseconds before any ramp.
// - Configured delay below seven milliseconds is replaced by seven milliseconds.
// - Configured delay above seven milliseconds is waited in full before ramping.
// - After the delay, output ramps to target over the strap-selected ramp time.
// - Two tri-level straps pick one of nine voltages, high strap picks row.
// - Resistor straps give a setpoint from 0.6 V to 5.0 V in 10 mV.
// - Coarse resistor index is four times setpoint volts, rounded down.
// - Fine index is hundred times volts minus 25 times coarse; rebuild accordingly.
// - Each resistor strap is one of 25 index codes, 0 through 24.
// - Setpoint written over the bus is accepted between 0.6 V and 5.5 V.
// - Straps are sampled at power-up and again on a restore command.
// - Enable and bus traffic are ignored during memory check and strap loading.
// - Output ceiling is ten percent above the strap-selected voltage.
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module pss_seq #(
  parameter int MS_CYCLES = pss_pkg::MS_CYCLES,
  parameter logic [7:0] MEMCHK_MS = pss_pkg::MEM_CHECK_MS,
  parameter logic [7:0] MIN_DELAY_MS = pss_pkg::PRE_RAMP_MS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Supply presence
  input wire logic logic_supply_input,
  input wire logic power_stage_supply_input,
  input wire logic bias_supply_input,
  // Enable
  input wire logic enable_in,
  // Straps
  input wire logic [1:0] setpoint_high_strap,
  input wire logic [1:0] setpoint_low_strap,
  input wire logic setpoint_resistor_mode,
  input wire logic [4:0] coarse_setpoint_index,
  input wire logic [4:0] fine_setpoint_index,
  input wire logic [1:0] delay_time_strap,
  input wire logic [1:0] ramp_time_strap,
  // Non-volatile memory contents
  input wire logic nvm_stored,
  input wire logic [12:0] nvm_setpoint_mv,
  input wire logic [7:0] nvm_delay_ms,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // Converter control
  output logic device_ready,
  output logic stage_enable,
  output logic ramping,
  output logic [12:0] vref_mv,
  output logic [12:0] output_ceiling
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] strap_ms(input logic [1:0] code);
    unique case (code)
      pss_pkg::TRI_LOW: strap_ms = pss_pkg::STRAP_MS_LOW;
      pss_pkg::TRI_HIGH: strap_ms = pss_pkg::STRAP_MS_HIGH;
      default: strap_ms = pss_pkg::STRAP_MS_OPEN;
    endcase
  endfunction

  function automatic logic [12:0] tri_pick(input logic [1:0] code, input logic [12:0] lo,
                                           input logic [12:0] mid, input logic [12:0] hi);
    unique case (code)
      pss_pkg::TRI_LOW: tri_pick = lo;
      pss_pkg::TRI_HIGH: tri_pick = hi;
      default: tri_pick = mid;
    endcase
  endfunction

  function automatic logic [12:0] ceil_of(input logic [12:0] sp);
    ceil_of = 13'((int'(sp) * pss_pkg::CEIL_NUM) / pss_pkg::CEIL_DEN);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pss_pkg::pss_state_t state_q, state_d;
  logic [15:0] ms_div_q;
  logic [7:0] ms_cnt_q;
  logic [12:0] setpoint_q;
  logic [7:0] delay_cfg_q;
  logic [7:0] ramp_ms_q;
  logic nvm_used_q;
  logic [15:0] frac_q;
  logic [15:0] rdata_q;
  logic ready_q, stage_en_q, ramping_q;
  logic [12:0] vref_q, ceiling_q;
  logic supplies_ok, ms_tick, state_chg, restore, ramp_step;
  logic [4:0] coarse_idx, fine_idx;
  logic [12:0] tri_sp, res_sp, strap_sp;
  logic [7:0] eff_delay;

  assign supplies_ok = logic_supply_input & power_stage_supply_input & bias_supply_input;
  assign ms_tick = (ms_div_q == 16'(MS_CYCLES - 1));
  assign state_chg = (state_d != state_q);
  // Bus traffic only counts once the device is ready
  assign restore = wr && ready_q && (addr == pss_pkg::REG_CTRL) &&
                   wdata[pss_pkg::CTRL_RESTORE_BIT];

  // ----------------------------------------------------------------
  // Setpoint decode
  // ----------------------------------------------------------------
  // Row from the high strap, column from the low strap
  always_comb begin
    unique case (setpoint_high_strap)
      pss_pkg::TRI_LOW:
        tri_sp = tri_pick(setpoint_low_strap, pss_pkg::SP_0V6_MV, pss_pkg::SP_0V8_MV,
                          pss_pkg::SP_1V0_MV);
      pss_pkg::TRI_HIGH:
        tri_sp = tri_pick(setpoint_low_strap, pss_pkg::SP_2V5_MV, pss_pkg::SP_3V3_MV,
                          pss_pkg::SP_5V0_MV);
      default:
        tri_sp = tri_pick(setpoint_low_strap, pss_pkg::SP_1V2_MV, pss_pkg::SP_1V5_MV,
                          pss_pkg::SP_1V8_MV);
    endcase
  end

  // Out-of-table resistor codes read as the top index
  assign coarse_idx = (coarse_setpoint_index > pss_pkg::IDX_MAX) ? pss_pkg::IDX_MAX :
                      coarse_setpoint_index;
  assign fine_idx = (fine_setpoint_index > pss_pkg::IDX_MAX) ? pss_pkg::IDX_MAX :
                    fine_setpoint_index;
  assign res_sp = 13'(13'(coarse_idx) * pss_pkg::COARSE_STEP_MV +
                  13'(fine_idx) * pss_pkg::FINE_STEP_MV);

  always_comb begin
    if (!setpoint_resistor_mode) begin
      strap_sp = tri_sp;
    end else if (res_sp < pss_pkg::SP_0V6_MV) begin
      strap_sp = pss_pkg::SP_0V6_MV;
    end else if (res_sp > pss_pkg::SP_5V0_MV) begin
      strap_sp = pss_pkg::SP_5V0_MV;
    end else begin
      strap_sp = res_sp;
    end
  end

  assign eff_delay = (delay_cfg_q < MIN_DELAY_MS) ? MIN_DELAY_MS : delay_cfg_q;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      pss_pkg::ST_PWR_WAIT: if (supplies_ok) state_d = pss_pkg::ST_MEM_CHECK;
      pss_pkg::ST_MEM_CHECK: if (ms_cnt_q == MEMCHK_MS) state_d = pss_pkg::ST_STRAP;
      pss_pkg::ST_STRAP: state_d = pss_pkg::ST_READY;
      pss_pkg::ST_READY: begin
        if (restore) state_d = pss_pkg::ST_MEM_CHECK;
        else if (enable_in) state_d = pss_pkg::ST_PRE_RAMP;
      end
      pss_pkg::ST_PRE_RAMP: begin
        if (restore) state_d = pss_pkg::ST_MEM_CHECK;
        else if (!enable_in) state_d = pss_pkg::ST_READY;
        else if (ms_cnt_q >= eff_delay) state_d = pss_pkg::ST_RAMP;
      end
      pss_pkg::ST_RAMP: begin
        if (restore) state_d = pss_pkg::ST_MEM_CHECK;
        else if (!enable_in) state_d = pss_pkg::ST_READY;
        else if (ms_cnt_q >= ramp_ms_q) state_d = pss_pkg::ST_ON;
      end
      pss_pkg::ST_ON: begin
        if (restore) state_d = pss_pkg::ST_MEM_CHECK;
        else if (!enable_in) state_d = pss_pkg::ST_READY;
      end
      default: state_d = pss_pkg::ST_PWR_WAIT;
    endcase
    // Losing any supply restarts from the top
    if (!supplies_ok) state_d = pss_pkg::ST_PWR_WAIT;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= pss_pkg::ST_PWR_WAIT;
    end else begin
      state_q <= state_d;
    end
  end

  // Millisecond timebase restarts with each state so intervals are exact
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_div_q <= 16'h0000;
      ms_cnt_q <= 8'h00;
    end else if (state_chg) begin
      ms_div_q <= 16'h0000;
      ms_cnt_q <= 8'h00;
    end else if (ms_tick) begin
      ms_div_q <= 16'h0000;
      if (ms_cnt_q != 8'hFF) ms_cnt_q <= ms_cnt_q + 8'h01;
    end else begin
      ms_div_q <= ms_div_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Working configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      setpoint_q <= pss_pkg::SETPOINT_RST;
      delay_cfg_q <= pss_pkg::DELAY_RST;
      ramp_ms_q <= pss_pkg::RAMP_RST;
      ceiling_q <= pss_pkg::SETPOINT_RST;
      nvm_used_q <= 1'b0;
    end else if (state_q == pss_pkg::ST_MEM_CHECK && state_d == pss_pkg::ST_STRAP) begin
      nvm_used_q <= nvm_stored;
      if (nvm_stored) begin
        setpoint_q <= nvm_setpoint_mv;
        delay_cfg_q <= nvm_delay_ms;
      end
    end else if (state_q == pss_pkg::ST_STRAP) begin
      ramp_ms_q <= strap_ms(ramp_time_strap);
      ceiling_q <= ceil_of(strap_sp);
      // Stored values win over pin settings
      if (!nvm_used_q) begin
        setpoint_q <= strap_sp;
        delay_cfg_q <= strap_ms(delay_time_strap);
      end
    end else if (wr && ready_q) begin
      if (addr == pss_pkg::REG_SETPOINT && wdata[12:0] >= pss_pkg::SP_0V6_MV &&
          wdata[12:0] <= pss_pkg::SP_BUS_MAX_MV && wdata[15:13] == 3'h0) begin
        setpoint_q <= wdata[12:0];
      end
      if (addr == pss_pkg::REG_DELAY) delay_cfg_q <= wdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Soft-start ramp
  // ----------------------------------------------------------------
  // Each ms adds the target into an accumulator; every ramp_ms drained is one
  // mV, giving a monotonic linear slope without a divider.
  assign ramp_step = (frac_q >= 16'(ramp_ms_q)) && (vref_q < setpoint_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vref_q <= 13'h0000;
      frac_q <= 16'h0000;
    end else if (state_q == pss_pkg::ST_RAMP && state_d == pss_pkg::ST_RAMP) begin
      if (ms_tick) begin
        frac_q <= frac_q + 16'(setpoint_q);
      end else if (ramp_step) begin
        frac_q <= frac_q - 16'(ramp_ms_q);
        vref_q <= vref_q + 13'h0001;
      end
    end else if (state_d == pss_pkg::ST_ON) begin
      vref_q <= setpoint_q;
      frac_q <= 16'h0000;
    end else begin
      vref_q <= 13'h0000;
      frac_q <= 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_q <= 1'b0;
      stage_en_q <= 1'b0;
      ramping_q <= 1'b0;
    end else begin
      ready_q <= state_d inside {pss_pkg::ST_READY, pss_pkg::ST_PRE_RAMP,
                                 pss_pkg::ST_RAMP, pss_pkg::ST_ON};
      stage_en_q <= state_d inside {pss_pkg::ST_RAMP, pss_pkg::ST_ON};
      ramping_q <= (state_d == pss_pkg::ST_RAMP);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= 16'h0000;
      if (rd && ready_q) begin
        unique case (addr)
          pss_pkg::REG_SETPOINT: rdata_q <= {3'h0, setpoint_q};
          pss_pkg::REG_DELAY: rdata_q <= {8'h00, delay_cfg_q};
          pss_pkg::REG_STATUS: begin
            rdata_q[pss_pkg::STAT_STATE_LSB +: 3] <= state_q;
            rdata_q[pss_pkg::STAT_READY_BIT] <= ready_q;
            rdata_q[pss_pkg::STAT_ON_BIT] <= stage_en_q;
            rdata_q[pss_pkg::STAT_NVM_BIT] <= nvm_used_q;
          end
          pss_pkg::REG_CEILING: rdata_q <= {3'h0, ceiling_q};
          pss_pkg::REG_RAMP: rdata_q <= {8'h00, ramp_ms_q};
          default: rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  assign rdata = rdata_q;
  assign device_ready = ready_q;
  assign stage_enable = stage_en_q;
  assign ramping = ramping_q;
  assign vref_mv = vref_q;
  assign output_ceiling = ceiling_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  supply_gate_a: assert property (
    !supplies_ok |=> state_q == pss_pkg::ST_PWR_WAIT && !stage_en_q)
    else $error("sequence ran without all supplies");
  memchk_time_a: assert property (
    state_q == pss_pkg::ST_MEM_CHECK && ms_cnt_q < MEMCHK_MS && supplies_ok
    |=> state_q == pss_pkg::ST_MEM_CHECK)
    else $error("memory check left early");
  nvm_load_a: assert property (
    state_q == pss_pkg::ST_MEM_CHECK && state_d == pss_pkg::ST_STRAP && nvm_stored
    |=> setpoint_q == $past(nvm_setpoint_mv) ##1 setpoint_q == $past(nvm_setpoint_mv, 2))
    else $error("stored setpoint not kept");
  strap_load_a: assert property (
    state_q == pss_pkg::ST_STRAP && supplies_ok
    |=> ramp_ms_q == strap_ms($past(ramp_time_strap)) && ready_q)
    else $error("ramp strap not loaded");
  busy_read_a: assert property (
    !ready_q && rd |=> rdata == 16'h0000)
    else $error("bus answered while busy");
  busy_enable_a: assert property (
    state_q inside {pss_pkg::ST_MEM_CHECK, pss_pkg::ST_STRAP} |=> !stage_en_q && !ramping_q)
    else $error("enable acted while busy");
  min_delay_a: assert property (
    state_q == pss_pkg::ST_PRE_RAMP && ms_cnt_q < MIN_DELAY_MS |=> !ramping_q)
    else $error("ramp before minimum delay");
  cfg_delay_a: assert property (
    state_q == pss_pkg::ST_PRE_RAMP && ms_cnt_q < delay_cfg_q |=> state_q != pss_pkg::ST_RAMP)
    else $error("ramp before configured delay");
  ramp_mono_a: assert property (
    state_q == pss_pkg::ST_RAMP && ramping_q && $stable(setpoint_q) && !wr &&
    state_d inside {pss_pkg::ST_RAMP, pss_pkg::ST_ON}
    |=> vref_q >= $past(vref_q) && vref_q <= setpoint_q)
    else $error("ramp not monotonic");
  bus_range_a: assert property (
    wr && ready_q && addr == pss_pkg::REG_SETPOINT && wdata[12:0] > pss_pkg::SP_BUS_MAX_MV
    |=> $stable(setpoint_q))
    else $error("out of range setpoint taken");
  ceiling_a: assert property (
    state_q == pss_pkg::ST_STRAP |=> output_ceiling == ceil_of($past(strap_sp)))
    else $error("ceiling not ten percent above strap");
  tri_decode_a: assert property (
    !setpoint_resistor_mode && setpoint_high_strap == pss_pkg::TRI_HIGH &&
    setpoint_low_strap == pss_pkg::TRI_LOW |-> strap_sp == pss_pkg::SP_2V5_MV)
    else $error("tri-level decode wrong");
  res_decode_a: assert property (
    setpoint_resistor_mode && coarse_setpoint_index == 5'h05 && fine_setpoint_index == 5'h08
    |-> strap_sp == 13'h0532)
    else $error("resistor decode wrong");

  startup_on_c: cover property (state_q == pss_pkg::ST_RAMP ##1 state_q == pss_pkg::ST_ON);
  restore_c: cover property (restore && state_q == pss_pkg::ST_ON);
  nvm_used_c: cover property (state_q == pss_pkg::ST_STRAP && nvm_used_q);

endmodule

// ### pss_far_end.sv
// Far-side model: supply rails and an enable source with a clock-settle guard
`timescale 1ns/1ps
module pss_far_end (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requests from the bench
  input wire logic [2:0] supply_mask,
  input wire logic want_en,
  // Pins toward the device
  output logic logic_supply_input,
  output logic power_stage_supply_input,
  output logic bias_supply_input,
  output logic enable_in
);
  logic [2:0] settle_q;

  assign logic_supply_input = supply_mask[0];
  assign power_stage_supply_input = supply_mask[1];
  assign bias_supply_input = supply_mask[2];

  // Sync source must be settled before enable rises, so enable lags the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_q <= 3'h0;
    end else if (!want_en) begin
      settle_q <= 3'h0;
    end else if (settle_q != 3'h7) begin
      settle_q <= settle_q + 3'h1;
    end
  end

  assign enable_in = (settle_q == 3'h7);
endmodule

// ### pol_startup_setpoint_seq_test.sv
// Self-checking bench for the start-up sequencer and setpoint decoder
`timescale 1ns/1ps
module pol_startup_setpoint_seq_test;
  logic clk = 1'b0, rst_n = 1'b0, want_en = 1'b0, mode = 1'b0, nvm_st = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [2:0] mask = 3'h0;
  logic [1:0] hi_s = 2'h1, lo_s = 2'h1;
  logic [1:0] dly_s = 2'h0, rmp_s = 2'h0;
  logic [12:0] nvm_sp = 13'h07D0;
  logic [7:0] nvm_dl = 8'h0C;
  int wr_v[6] = '{1330, 599, 5501, 600, 5500, 8192};
  int ex_v[6] = '{1330, 1330, 1330, 600, 5500, 5500};
  int ms_tab[3] = '{10, 50, 100};
  logic [4:0] c_idx = 5'h00, f_idx = 5'h00;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rv;
  logic [31:0] seed = 32'h0000_6f75;
  logic l_sup, p_sup, b_sup, en, ready, stage, ramping;
  logic [15:0] rdata;
  logic [12:0] vref, ceil;
  int failures = 0, n_checks = 0, cyc = 0, n;

  pss_far_end far_u (.clk(clk), .rst_n(rst_n), .supply_mask(mask), .want_en(want_en),
    .logic_supply_input(l_sup), .power_stage_supply_input(p_sup), .bias_supply_input(b_sup),
    .enable_in(en));
  // Short millisecond so the long counts fit the run
  pss_seq #(.MS_CYCLES(10), .MEMCHK_MS(8'h0F), .MIN_DELAY_MS(8'h07)) dut_u (.clk(clk),
    .rst_n(rst_n), .logic_supply_input(l_sup), .power_stage_supply_input(p_sup),
    .bias_supply_input(b_sup), .enable_in(en), .setpoint_high_strap(hi_s),
    .setpoint_low_strap(lo_s), .setpoint_resistor_mode(mode), .coarse_setpoint_index(c_idx),
    .fine_setpoint_index(f_idx), .delay_time_strap(dly_s), .ramp_time_strap(rmp_s),
    .nvm_stored(nvm_st), .nvm_setpoint_mv(nvm_sp), .nvm_delay_ms(nvm_dl), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .device_ready(ready), .stage_enable(stage),
    .ramping(ramping), .vref_mv(vref), .output_ceiling(ceil));

  initial forever #20 clk = ~clk;

  // ----------------------------------------------------------------
  // Checking and expectations
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_win(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      failures++;
      $display("mismatch t=%0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] tri_mv(input int r, input int c);
    int t[9] = '{600, 800, 1000, 1200, 1500, 1800, 2500, 3300, 5000};
    return 16'(t[r * 3 + c]);
  endfunction
  function automatic logic [15:0] res_mv(input logic [4:0] c, input logic [4:0] f);
    int v;
    v = (c > 24 ? 24 : int'(c)) * 250 + (f > 24 ? 24 : int'(f)) * 10;
    return 16'(v < 600 ? 600 : (v > 5000 ? 5000 : v));
  endfunction

  // ----------------------------------------------------------------
  // Register port and sequencing tasks
  // ----------------------------------------------------------------
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic await_ready(output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while (!(ready === 1'b1 && k > 5) && k < 1000);
  endtask
  task automatic restore(output int k);
    wr_reg(pss_pkg::REG_CTRL, 16'h0001);
    await_ready(k);
  endtask
  task automatic run_ramp(input int ms, input logic [15:0] sp);
    want_en <= 1'b1;
    wait (en === 1'b1);
    // Look just after each edge so the value launched there has settled
    for (n = 0; stage !== 1'b1 && n < 2000; n++) begin
      @(posedge clk);
      #1;
    end
    chk_win(n, ms * 10 - 1, ms * 10 + 3);
    for (n = 0; ramping === 1'b1 && n < 2000; n++) begin
      @(posedge clk);
      #1;
    end
    chk_win(n, 98, 103);
    #1 chk(16'(vref), sp);
    @(posedge clk);
    want_en <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      report_and_stop;
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    mask <= 3'h3;
    want_en <= 1'b1;
    wr_reg(pss_pkg::REG_SETPOINT, 16'h0532);
    repeat (300) @(posedge clk);
    chk(16'(ready), 16'h0000);
    want_en <= 1'b0;
    mask <= 3'h7;
    wr_reg(pss_pkg::REG_SETPOINT, 16'h0532);
    rd_reg(pss_pkg::REG_STATUS, rv);
    chk(rv, 16'h0000);
    await_ready(n);
    chk_win(n, 146, 160);
    chk(16'(stage), 16'h0000);
    rd_reg(pss_pkg::REG_SETPOINT, rv);
    chk(rv, 16'h05DC);
    wr_reg(pss_pkg::REG_DELAY, 16'h0003);
    run_ramp(7, 16'h05DC);
    wr_reg(pss_pkg::REG_DELAY, 16'h0009);
    run_ramp(9, 16'h05DC);
    // Bus setpoint limits, each value followed by its read-back
    foreach (wr_v[i]) begin
      wr_reg(pss_pkg::REG_SETPOINT, 16'(wr_v[i]));
      rd_reg(pss_pkg::REG_SETPOINT, rv);
      chk(rv, 16'(ex_v[i]));
    end
    wr_reg(4'hF, 16'hFFFF);
    rd_reg(4'hF, rv);
    chk(rv, 16'h0000);
    for (int i = 0; i < 9; i++) begin
      hi_s <= 2'(i / 3);
      lo_s <= 2'(i % 3);
      dly_s <= 2'(i % 3);
      rmp_s <= 2'(i / 3);
      restore(n);
      chk_win(n, 146, 160);
      rd_reg(pss_pkg::REG_SETPOINT, rv);
      chk(rv, tri_mv(i / 3, i % 3));
      rd_reg(pss_pkg::REG_CEILING, rv);
      chk(rv, 16'(tri_mv(i / 3, i % 3) * 11 / 10));
      chk(16'(ceil), 16'(tri_mv(i / 3, i % 3) * 11 / 10));
      rd_reg(pss_pkg::REG_RAMP, rv);
      chk(rv, 16'(ms_tab[i / 3]));
      rd_reg(pss_pkg::REG_DELAY, rv);
      chk(rv, 16'(ms_tab[i % 3]));
    end
    mode <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      c_idx <= (i == 0) ? 5'h05 : seed[4:0];
      f_idx <= (i == 0) ? 5'h08 : seed[9:5];
      restore(n);
      rd_reg(pss_pkg::REG_SETPOINT, rv);
      chk(rv, (i == 0) ? 16'h0532 : res_mv(seed[4:0], seed[9:5]));
    end
    mode <= 1'b0;
    // Short ramp strap again so the final ramp window holds
    rmp_s <= 2'h0;
    nvm_st <= 1'b1;
    restore(n);
    rd_reg(pss_pkg::REG_SETPOINT, rv);
    chk(rv, 16'h07D0);
    rd_reg(pss_pkg::REG_DELAY, rv);
    chk(rv, 16'h000C);
    rd_reg(pss_pkg::REG_STATUS, rv);
    chk(16'(rv[pss_pkg::STAT_NVM_BIT]), 16'h0001);
    run_ramp(12, 16'h07D0);
    report_and_stop;
  end
endmodule
